// ---- inc/sap_consts.vh ----
/*
 constants for the serial audio port flag and control block:
 register offsets, field positions, reset values and timing counts.
 assumes inclusion by bare name from the design file.
*/
`ifndef SAP_CONSTS_VH
`define SAP_CONSTS_VH

// register byte offsets
`define SAP_OFF_CTL0        8'h00
`define SAP_OFF_CTL1        8'h04
`define SAP_OFF_STAT        8'h08
`define SAP_OFF_DATA        8'h0C
`define SAP_OFF_AUDIO       8'h1C

// reset values
`define SAP_RST_CTL0        16'h0000
`define SAP_RST_CTL1        16'h0000
`define SAP_RST_STAT        16'h0002
`define SAP_RST_AUDIO       16'h0000

// serial_control_0 fields
`define SAP_C0_BIDIR        15
`define SAP_C0_BIDIR_OUT    14
`define SAP_C0_CRC_EN       13
`define SAP_C0_CRC_NEXT     12
`define SAP_C0_WIDE         11
`define SAP_C0_RX_ONLY      10
`define SAP_C0_SOFT_SEL_EN  9
`define SAP_C0_SOFT_SEL     8
`define SAP_C0_LSB_FIRST    7
`define SAP_C0_PORT_EN      6
`define SAP_C0_DIV_HI       5
`define SAP_C0_DIV_LO       3
`define SAP_C0_MASTER       2
`define SAP_C0_CLK_IDLE     1
`define SAP_C0_CLK_PHASE    0

// serial_control_1 fields
`define SAP_C1_TXE_IE       7
`define SAP_C1_RXF_IE       6
`define SAP_C1_ERR_IE       5
`define SAP_C1_TI_MODE      4
`define SAP_C1_SEL_PULSE    3
`define SAP_C1_SEL_DRIVE    2
`define SAP_C1_TX_DMA       1
`define SAP_C1_RX_DMA       0

// serial_status fields
`define SAP_ST_FRAME_ERR    8
`define SAP_ST_BUSY         7
`define SAP_ST_OVERRUN      6
`define SAP_ST_CFG_FAULT    5
`define SAP_ST_CRC_ERR      4
`define SAP_ST_UNDERRUN     3
`define SAP_ST_CHAN         2
`define SAP_ST_TX_EMPTY     1
`define SAP_ST_RX_FULL      0

// audio control fields
`define SAP_AU_EN           10
`define SAP_AU_MODE_HI      9
`define SAP_AU_MODE_LO      8
`define SAP_AU_STD_HI       5
`define SAP_AU_STD_LO       4
`define SAP_AU_CLK_IDLE     3
`define SAP_AU_CHLEN        0

// slave modes and the pcm standard code
`define SAP_MODE_SLV_TX     2'b00
`define SAP_MODE_SLV_RX     2'b01
`define SAP_STD_PCM         2'b11

// audio word is 16 bits, channel slot 16 or 32 bit clocks
`define SAP_WORD_BITS       5'd16
`define SAP_SLOT_SHORT      6'd16
`define SAP_SLOT_LONG       6'd32

`endif

// ---- tb/sap_audio_master.sv ----
/* external audio master: bit clock, word select and receive data.
   assumes 16 clocks per slot, clock idle low and still between slots. */
`timescale 1ns/1ps
`default_nettype none
module sap_audio_master (
    output logic      bit_clk,
    output logic      word_select_line,
    output logic      sd_in,
    input  wire logic sd_out
);
    initial begin
        bit_clk = 1'b0;
        word_select_line = 1'b1;
        sd_in = 1'b0;
    end
    // one slot, 160 ns a bit; glitch toggles select at that bit, -1 for none
    task automatic slot(input logic [15:0] rxw, input int glitch, output logic [15:0] txw);
        for (int i = 15; i >= 0; i--) begin
            if (i == 15) word_select_line = ~word_select_line;
            #40 bit_clk = 1'b1;
            #20 sd_in = rxw[i];
            #60 bit_clk = 1'b0;
            if (i == glitch) word_select_line = ~word_select_line;
            // hold time over: show the inverse so a stale bit cannot pass
            #30 sd_in = ~rxw[i];
            txw[i] = sd_out;
            #10;
        end
    endtask
endmodule // sap_audio_master
`default_nettype wire

// ---- tb/sap_checker.sv ----
/* assertions on the serial audio port outputs.
   assumes single-word ahb transfers, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module sap_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // link, dma and interrupt
    input wire logic        sd_oe,
    input wire logic        serial_clk_tick,
    input wire logic        tx_dma_req,
    input wire logic        rx_dma_req,
    input wire logic        irq
);
    logic        ph_q;
    logic        wr_q;
    logic [7:0]  ad_q;
    logic [15:0] c0_q;
    logic [15:0] c1_q;
    logic [15:0] au_q;
    logic        take;
    assign take = hsel && hready && htrans[1];
    // shadow the control writes so enables are known from the ports alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            ad_q <= 8'h00;
            c0_q <= 16'h0000;
            c1_q <= 16'h0000;
            au_q <= 16'h0000;
        end else begin
            ph_q <= take;
            wr_q <= hwrite;
            ad_q <= haddr;
            if (ph_q && wr_q && ad_q == 8'h00) c0_q <= hwdata[15:0];
            if (ph_q && wr_q && ad_q == 8'h04) c1_q <= hwdata[15:0];
            if (ph_q && wr_q && ad_q == 8'h1C) au_q <= hwdata[15:0];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    rdy_ok_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    txdma_en_a: assert property ($rose(tx_dma_req) |-> c1_q[1])
        else $error("tx dma request without enable");
    rxdma_off_a: assert property ((!c1_q[0]) [*3] |-> !rx_dma_req)
        else $error("rx dma request without enable");
    irq_off_a: assert property ((c1_q[7:5] == 3'b000) [*3] |-> !irq)
        else $error("interrupt with all enables off");
    rd_clr_a: assert property (take && !hwrite && haddr == 8'h0C && c1_q[0]
        |-> ##[1:3] !rx_dma_req) else $error("data read left rx request up");
    wr_clr_a: assert property (ph_q && wr_q && ad_q == 8'h0C && c1_q[1]
        |-> ##[1:3] !tx_dma_req) else $error("data write left tx request up");
    oe_off_a: assert property ((!au_q[10]) [*3] |-> !sd_oe)
        else $error("data driven while port disabled");
    tick_off_a: assert property ((!c0_q[2]) [*3] |-> !serial_clk_tick)
        else $error("serial clock tick outside master mode");
    tick_pulse_a: assert property (serial_clk_tick |=> !serial_clk_tick)
        else $error("serial clock tick longer than one cycle");
    cover property (serial_clk_tick);
    cover property ($rose(tx_dma_req));
    cover property ($rose(rx_dma_req));
    cover property ($rose(irq));
endmodule // sap_checker
bind sap_port sap_checker u_chk (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .sd_oe(sd_oe), .serial_clk_tick(serial_clk_tick),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .irq(irq));
`default_nettype wire

// ---- tb/tb_top.sv ----
/* self-checking bench for the serial audio port: register table rows,
   then slave transmit, slave receive and framing cases. assumes sap_port. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic dma; logic irq;} sap_row_t;
    logic        clk;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, bit_clk, ws, sd_in, sd_out, sd_oe;
    logic        select_out, select_oe, tick, tx_dma_req, rx_dma_req, irq;
    logic [15:0] tw;
    logic [31:0] r;
    logic        sel_pin = 1'b1;
    int          fail_count = 0;
    int          cmp_count = 0;
    sap_row_t    rows [13] = '{
        '{1'b0, 8'h00, 32'h0, 1'b0, 1'b0}, '{1'b0, 8'h04, 32'h0, 1'b0, 1'b0},
        '{1'b0, 8'h08, 32'h2, 1'b0, 1'b0}, '{1'b1, 8'h10, 32'hFFFFFFFF, 1'b0, 1'b0},
        '{1'b0, 8'h10, 32'h0, 1'b0, 1'b0}, '{1'b1, 8'h04, 32'h82, 1'b1, 1'b1},
        '{1'b1, 8'h04, 32'h2, 1'b1, 1'b0}, '{1'b1, 8'h04, 32'h80, 1'b0, 1'b1},
        '{1'b1, 8'h04, 32'h0, 1'b0, 1'b0}, '{1'b1, 8'h00, 32'h1234, 1'b0, 1'b0},
        '{1'b0, 8'h00, 32'h1234, 1'b0, 1'b0}, '{1'b1, 8'h08, 32'h0, 1'b0, 1'b0},
        '{1'b0, 8'h08, 32'h2, 1'b0, 1'b0}};
    sap_port dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .bit_clk(bit_clk), .word_select_line(ws),
        .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe), .select_pin(sel_pin),
        .select_out(select_out), .select_oe(select_oe), .serial_clk_tick(tick),
        .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .irq(irq));
    sap_audio_master am (.bit_clk(bit_clk), .word_select_line(ws), .sd_in(sd_in),
        .sd_out(sd_out));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(n, e, x & m);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, r);
            if (!rows[i].w) chk("row data", rows[i].d, r);
            repeat (3) @(posedge clk);
            chk("row dma irq", {30'h0, rows[i].dma, rows[i].irq}, {30'h0, tx_dma_req, irq});
        end
        // select: pin followed, then soft level, then driven low as enabled master
        wr(8'h00, 32'h0004);
        sel_pin <= 1'b0;
        repeat (4) @(posedge clk);
        chk("select pin", 32'h0, {30'h0, select_oe, select_out});
        wr(8'h00, 32'h0304);
        repeat (3) @(posedge clk);
        chk("select soft", 32'h1, {30'h0, select_oe, select_out});
        wr(8'h04, 32'h0004);
        wr(8'h00, 32'h0344);
        repeat (3) @(posedge clk);
        chk("select drive", 32'h2, {30'h0, select_oe, select_out});
        wr(8'h00, 32'h0000);
        // slave transmit: word preloaded, second written mid-slot, third slot starved
        wr(8'h04, 32'h23);
        wr(8'h0C, 32'hA5C3);
        rchk("tx empty", 8'h08, 32'h2, 32'h0);
        wr(8'h1C, 32'h400);
        fork
            am.slot(16'h0, -1, tw);
            begin
                repeat (40) @(posedge clk);
                rchk("tx status", 8'h08, 32'h86, 32'h86);
                wr(8'h0C, 32'h3C5A);
            end
        join
        chk("tx word", 32'hA5C3, {16'h0, tw});
        am.slot(16'h0, -1, tw);
        chk("tx next", 32'h3C5A, {16'h0, tw});
        am.slot(16'h0, -1, tw);
        repeat (6) @(posedge clk);
        chk("underrun irq", 32'h1, {31'h0, irq});
        rchk("underrun", 8'h08, 32'h8, 32'h8);
        rchk("underrun clr", 8'h08, 32'h8, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        rchk("tx idle", 8'h08, 32'h82, 32'h2);
        wr(8'h1C, 32'h0);
        // slave receive, then overrun on two unread words
        wr(8'h1C, 32'h500);
        am.slot(16'h1234, -1, tw);
        repeat (4) @(posedge clk);
        chk("rx dma", 32'h1, {31'h0, rx_dma_req});
        rchk("rx status", 8'h08, 32'h5, {29'h0, ws, 2'b01});
        rchk("rx word", 8'h0C, 32'hFFFF, 32'h1234);
        rchk("rx cleared", 8'h08, 32'h1, 32'h0);
        am.slot(16'hBEEF, -1, tw);
        am.slot(16'h5555, -1, tw);
        repeat (4) @(posedge clk);
        chk("overrun irq", 32'h1, {31'h0, irq});
        rchk("overrun", 8'h08, 32'h41, 32'h41);
        rchk("overrun held", 8'h08, 32'h40, 32'h40);
        rchk("old word", 8'h0C, 32'hFFFF, 32'hBEEF);
        bus(1'b0, 8'h08, 32'h0, r);
        rchk("overrun clr", 8'h08, 32'h40, 32'h0);
        wr(8'h1C, 32'h0);
        // select line moved in mid-slot
        wr(8'h1C, 32'h500);
        am.slot(16'h0, 5, tw);
        repeat (4) @(posedge clk);
        rchk("frame fault", 8'h08, 32'h100, 32'h100);
        wr(8'h08, 32'h0);
        rchk("frame clr", 8'h08, 32'h100, 32'h0);
        // reset in mid-run, in the same cycle that the tx dma and empty interrupt enables are written, with tx_dma_req already high and before irq rises
        wr(8'h04, 32'h82);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rchk("reset status", 8'h08, 32'h1FF, 32'h2);
        rchk("reset ctl1", 8'h04, 32'hFFFF, 32'h0);
        chk("reset dma irq", 32'h0, {30'h0, tx_dma_req, irq});
        conclude();
    end
endmodule // tb_top
`default_nettype wire

// ---- verilog/sap_port.v ----
/*
 serial audio port, slave side: ahb-lite register slave with control,
 status and data registers, audio slave transmit and receive engine,
 status and error flags, dma requests and a level interrupt.
 assumes one 50 MHz clk, an external audio master driving bit clock and
 word select (asynchronous, synchronised here), single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sap_consts.vh"

module sap_port (
    // clock and reset
    input  wire        clk,
    input  wire        resetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // audio link pins from the external master
    input  wire        bit_clk,
    input  wire        word_select_line,
    input  wire        sd_in,
    output reg         sd_out,
    output reg         sd_oe,
    // serial mode select pin and controls
    input  wire        select_pin,
    output reg         select_out,
    output reg         select_oe,
    output reg         serial_clk_tick,
    // dma and interrupt
    output reg         tx_dma_req,
    output reg         rx_dma_req,
    output reg         irq
);

    // register state
    reg  [15:0] ctl0_q;
    reg  [15:0] ctl1_q;
    reg  [15:0] audio_q;
    reg  [15:0] tx_buf_q;
    reg  [15:0] rx_buf_q;
    reg         tx_empty_q;
    reg         rx_full_q;
    reg         chan_q;
    reg         underrun_q;
    reg         overrun_q;
    reg         ovr_armed_q;
    reg         frame_err_q;
    reg         busy_q;

    // shift engine state
    reg  [15:0] shift_q;
    reg  [5:0]  bitpos_q;
    reg         started_q;
    reg         ws_prev_q;
    reg         word_side_q;
    reg         tx_loaded_q;

    // ahb address phase capture
    reg         wr_pend_q;
    reg         rd_pend_q;
    reg  [7:0]  addr_q;

    // synchronisers: first stage read only by second stage
    reg  [1:0]  ck_sync_q;
    reg  [1:0]  ws_sync_q;
    reg  [1:0]  sd_sync_q;
    reg  [1:0]  sel_sync_q;
    reg         ck_prev_q;

    // serial master clock divider
    reg  [7:0]  div_cnt_q;

    wire        ck_s     = ck_sync_q[1];
    wire        ws_s     = ws_sync_q[1];
    wire        sd_s     = sd_sync_q[1];
    wire        sel_s    = sel_sync_q[1];
    wire        au_en    = audio_q[`SAP_AU_EN];
    wire [1:0]  au_mode  = audio_q[`SAP_AU_MODE_HI:`SAP_AU_MODE_LO];
    wire        au_pcm   = (audio_q[`SAP_AU_STD_HI:`SAP_AU_STD_LO] == `SAP_STD_PCM);
    wire        ck_idle  = audio_q[`SAP_AU_CLK_IDLE];
    wire [5:0]  slot_len = audio_q[`SAP_AU_CHLEN] ? `SAP_SLOT_LONG : `SAP_SLOT_SHORT;
    wire        slv_tx   = au_en && (au_mode == `SAP_MODE_SLV_TX);
    wire        slv_rx   = au_en && (au_mode == `SAP_MODE_SLV_RX);

    // active edges relative to the idle level: drive on leaving idle, sample on return
    wire        ck_lead  = (ck_s != ck_idle) && (ck_prev_q == ck_idle);
    wire        ck_trail = (ck_s == ck_idle) && (ck_prev_q != ck_idle);
    wire        ws_edge  = (ws_s != ws_prev_q);

    // bus decode
    wire        ahb_go   = hsel && hready && htrans[1];
    wire        wr_ctl0  = wr_pend_q && (addr_q == `SAP_OFF_CTL0);
    wire        wr_ctl1  = wr_pend_q && (addr_q == `SAP_OFF_CTL1);
    wire        wr_data  = wr_pend_q && (addr_q == `SAP_OFF_DATA);
    wire        wr_audio = wr_pend_q && (addr_q == `SAP_OFF_AUDIO);
    wire        rd_stat  = rd_pend_q && (addr_q == `SAP_OFF_STAT);
    wire        rd_data  = rd_pend_q && (addr_q == `SAP_OFF_DATA);
    wire        wr_stat  = wr_pend_q && (addr_q == `SAP_OFF_STAT);

    // a word begins at slot start on the leading edge after a word select change or once a started slot reaches slot_len
    wire        slot_start = ck_lead && (ws_edge || (started_q && bitpos_q == slot_len));
    wire        word_done  = ck_trail && started_q && (bitpos_q == {1'b0, `SAP_WORD_BITS});
    wire        tx_load    = slv_tx && slot_start;
    // a write landing on the load edge goes straight to the shifter, not the stale buffer
    wire [15:0] tx_src     = wr_data ? hwdata[15:0] : tx_buf_q;
    wire        rx_word    = slv_rx && word_done;

    // status word as seen by software; the serial-only flags stay zero in audio mode
    wire [15:0] stat_word = {7'h00, frame_err_q, busy_q, overrun_q, 1'b0, 1'b0,
                             underrun_q, chan_q, tx_empty_q, rx_full_q};

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ck_sync_q  <= 2'b00;
            ws_sync_q  <= 2'b00;
            sd_sync_q  <= 2'b00;
            sel_sync_q <= 2'b11;
            ck_prev_q  <= 1'b0;
            ws_prev_q  <= 1'b0;
        end else begin
            ck_sync_q  <= {ck_sync_q[0], bit_clk};
            ws_sync_q  <= {ws_sync_q[0], word_select_line};
            sd_sync_q  <= {sd_sync_q[0], sd_in};
            sel_sync_q <= {sel_sync_q[0], select_pin};
            ck_prev_q  <= ck_s;
            // track the idle select level while disabled so the first toggle reads as an edge
            if (ck_lead || !au_en) begin
                ws_prev_q <= ws_s;
            end
        end
    end

    // ahb-lite slave: zero wait states, always okay, unmapped reads give zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= ahb_go && hwrite;
            rd_pend_q <= ahb_go && !hwrite;
            if (ahb_go) begin
                addr_q <= haddr;
            end
            if (ahb_go && !hwrite) begin
                case (haddr)
                    `SAP_OFF_CTL0:  hrdata <= {16'h0000, ctl0_q};
                    `SAP_OFF_CTL1:  hrdata <= {16'h0000, ctl1_q};
                    `SAP_OFF_STAT:  hrdata <= {16'h0000, stat_word};
                    `SAP_OFF_DATA:  hrdata <= {16'h0000, rx_buf_q};
                    `SAP_OFF_AUDIO: hrdata <= {16'h0000, audio_q};
                    default:        hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // control registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl0_q  <= `SAP_RST_CTL0;
            ctl1_q  <= `SAP_RST_CTL1;
            audio_q <= `SAP_RST_AUDIO;
        end else begin
            if (wr_ctl0) begin
                ctl0_q <= hwdata[15:0];
            end
            if (wr_ctl1) begin
                ctl1_q <= hwdata[15:0];
            end
            if (wr_audio) begin
                audio_q <= {4'h0, hwdata[11:7], 1'b0, hwdata[5:0]};
            end
        end
    end

    // buffers, flags and shift engine
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_buf_q    <= 16'h0000;
            rx_buf_q    <= 16'h0000;
            tx_empty_q  <= 1'b1;
            rx_full_q   <= 1'b0;
            chan_q      <= 1'b0;
            underrun_q  <= 1'b0;
            overrun_q   <= 1'b0;
            ovr_armed_q <= 1'b0;
            frame_err_q <= 1'b0;
            busy_q      <= 1'b0;
            shift_q     <= 16'h0000;
            bitpos_q    <= 6'd0;
            started_q   <= 1'b0;
            word_side_q <= 1'b0;
            tx_loaded_q <= 1'b0;
            sd_out      <= 1'b0;
            sd_oe       <= 1'b0;
        end else begin
            // data write fills the transmit buffer
            if (wr_data) begin
                tx_buf_q   <= hwdata[15:0];
                tx_empty_q <= 1'b0;
            end
            // data read empties the receive buffer and arms the overrun clear
            if (rd_data) begin
                rx_full_q <= 1'b0;
                if (overrun_q) begin
                    ovr_armed_q <= 1'b1;
                end
            end
            // status read clears underrun, and overrun after a data read
            if (rd_stat) begin
                underrun_q <= 1'b0;
                if (ovr_armed_q) begin
                    overrun_q   <= 1'b0;
                    ovr_armed_q <= 1'b0;
                end
            end
            // framing fault cleared by writing zero
            if (wr_stat && !hwdata[`SAP_ST_FRAME_ERR]) begin
                frame_err_q <= 1'b0;
            end
            if (!au_en) begin
                // disabling stops the engine but keeps underrun; only a status read clearing underrun ends an underrun stall
                started_q   <= 1'b0;
                tx_loaded_q <= 1'b0;
                busy_q      <= 1'b0;
                bitpos_q    <= 6'd0;
                sd_oe       <= 1'b0;
            end else begin
                sd_oe <= slv_tx;
                if (ck_lead && started_q && bitpos_q != slot_len) begin
                    bitpos_q <= bitpos_q + 6'd1;
                end
                // outside pcm, word select must only toggle at a slot boundary
                if (ck_lead && ws_edge && started_q && bitpos_q != slot_len
                    && !au_pcm) begin
                    frame_err_q <= 1'b1;
                end
                if (slot_start) begin
                    started_q   <= 1'b1;
                    bitpos_q    <= 6'd1;
                    busy_q      <= 1'b1;
                    word_side_q <= ws_s;
                end
                if (tx_load && !underrun_q) begin
                    if (tx_empty_q && !wr_data) begin
                        underrun_q  <= 1'b1;
                        tx_loaded_q <= 1'b0;
                        sd_out      <= 1'b0;
                    end else begin
                        shift_q     <= {tx_src[14:0], 1'b0};
                        sd_out      <= tx_src[15];
                        tx_loaded_q <= 1'b1;
                        tx_empty_q  <= 1'b1;
                        chan_q      <= !ws_s;
                    end
                end else if (slv_tx && ck_lead && started_q && !slot_start) begin
                    sd_out  <= tx_loaded_q ? shift_q[15] : 1'b0;
                    shift_q <= {shift_q[14:0], 1'b0};
                end
                if (slv_rx && ck_trail && started_q && bitpos_q <= {1'b0, `SAP_WORD_BITS}) begin
                    shift_q <= {shift_q[14:0], sd_s};
                end
                if (rx_word) begin
                    if (rx_full_q && !rd_data) begin
                        overrun_q <= 1'b1;
                    end else begin
                        rx_buf_q  <= {shift_q[14:0], sd_s};
                        rx_full_q <= 1'b1;
                        chan_q    <= word_side_q;
                    end
                end
                if (word_done && tx_empty_q && !slv_rx) begin
                    busy_q <= 1'b0;
                end else if (rx_word) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // serial master clock divider: code n divides by 2^(n+1)
    wire [2:0] div_code = ctl0_q[`SAP_C0_DIV_HI:`SAP_C0_DIV_LO];
    wire [7:0] div_last = (8'h02 << div_code) - 8'h01;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q       <= 8'h00;
            serial_clk_tick <= 1'b0;
        end else if (ctl0_q[`SAP_C0_MASTER] && ctl0_q[`SAP_C0_PORT_EN] && !au_en) begin
            serial_clk_tick <= (div_cnt_q == div_last);
            div_cnt_q       <= (div_cnt_q == div_last) ? 8'h00 : div_cnt_q + 8'h01;
        end else begin
            div_cnt_q       <= 8'h00;
            serial_clk_tick <= 1'b0;
        end
    end

    // select handling, dma and interrupt outputs
    wire sel_level = ctl0_q[`SAP_C0_SOFT_SEL_EN] ? ctl0_q[`SAP_C0_SOFT_SEL] : sel_s;
    wire err_any   = underrun_q || overrun_q || frame_err_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            select_out <= 1'b1;
            select_oe  <= 1'b0;
            tx_dma_req <= 1'b0;
            rx_dma_req <= 1'b0;
            irq        <= 1'b0;
        end else begin
            select_oe  <= ctl1_q[`SAP_C1_SEL_DRIVE] && ctl0_q[`SAP_C0_MASTER]
                          && ctl0_q[`SAP_C0_PORT_EN];
            select_out <= (ctl1_q[`SAP_C1_SEL_DRIVE] && ctl0_q[`SAP_C0_MASTER]
                          && ctl0_q[`SAP_C0_PORT_EN]) ? 1'b0 : sel_level;
            tx_dma_req <= ctl1_q[`SAP_C1_TX_DMA] && tx_empty_q;
            rx_dma_req <= ctl1_q[`SAP_C1_RX_DMA] && rx_full_q;
            irq        <= (ctl1_q[`SAP_C1_TXE_IE] && tx_empty_q)
                        || (ctl1_q[`SAP_C1_RXF_IE] && rx_full_q)
                        || (ctl1_q[`SAP_C1_ERR_IE] && err_any);
        end
    end

endmodule // sap_port
`default_nettype wire
